// ### chpc_halt_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module chpc_halt_ctrl
    import chpc_pkg::*;
#(
    parameter int N    = CHPC_NUM_PERIPH,
    parameter int PC_W = CHPC_PC_W
) (
    input  wire logic            i_clk_sys,
    input  wire logic            i_rst,
    input  wire logic            i_halt_exec,
    input  wire logic            i_irq_pend,
    input  wire logic            i_wdt_irq,
    input  wire logic            i_wdt_rst,
    input  wire logic            i_por,
    input  wire logic            i_bor,
    input  wire logic            i_ext_rst,
    input  wire logic            i_wdt_en,
    input  wire logic            i_pc_step,
    input  wire logic [PC_W-1:0] i_pc_next,
    input  wire logic [N-1:0]    i_periph_dis,
    input  wire logic [N-1:0]    i_pwr_cut_sel,
    output logic                 o_core_run,
    output logic                 o_core_idle,
    output logic                 o_core_rst,
    output logic                 o_irq_service,
    output logic [PC_W-1:0]      o_pc,
    output logic                 o_osc_en,
    output logic                 o_sysclk_en,
    output logic                 o_wdt_osc_en,
    output logic                 o_wdt_cnt_en,
    output logic [N-1:0]         o_periph_clk_en,
    output logic [N-1:0]         o_periph_pwr_en
);
    localparam logic [2:0] RST_SEQ_LAST = 3'(CHPC_RST_SEQ_CYC - 1);

    chpc_state_e  state_q;
    chpc_state_e  state_d;
    logic [PC_W-1:0] pc_q;
    logic [2:0]   seq_cnt_q;
    logic         run_q;
    logic         idle_q;
    logic         core_rst_q;
    logic         irq_srv_q;
    logic         wdt_cnt_q;
    logic [N-1:0] clk_en_q;
    logic [N-1:0] pwr_en_q;

    chpc_gate_if #(.N(N)) gif ();

    // Any reset source restarts the core, even from idle
    wire any_rst_w  = i_rst | i_por | i_bor | i_ext_rst | i_wdt_rst;
    wire irq_wake_w = i_irq_pend | i_wdt_irq;
    wire seq_done_w = (seq_cnt_q == RST_SEQ_LAST);

    // State decodes shared by the transition, counter and status logic
    wire in_reset_w = (state_q == CHPC_ST_RESET);
    wire in_run_w   = (state_q == CHPC_ST_RUN);
    wire in_idle_w  = (state_q == CHPC_ST_IDLE);

    // Halt is refused while a wake is pending, so no interrupt is lost
    wire halt_go_w  = in_run_w & i_halt_exec & ~irq_wake_w;
    // The halt cycle itself must not step the counter
    wire pc_adv_w   = in_run_w & i_pc_step & ~i_halt_exec;

    // Next state; a pending wake beats a new halt so no interrupt is lost
    always_comb begin
        state_d = state_q;
        case (state_q)
            CHPC_ST_RESET: begin
                if (seq_done_w) begin
                    state_d = CHPC_ST_RUN;
                end
            end
            CHPC_ST_RUN: begin
                if (halt_go_w) begin
                    state_d = CHPC_ST_IDLE;
                end
            end
            CHPC_ST_IDLE: begin
                if (irq_wake_w) begin
                    state_d = CHPC_ST_RUN;
                end
            end
            default: state_d = CHPC_ST_RESET;
        endcase
        if (any_rst_w) begin
            state_d = CHPC_ST_RESET;
        end
    end

    // Registered state; every reset source forces the restart path
    always_ff @(posedge i_clk_sys) begin
        if (any_rst_w) begin
            state_q <= CHPC_ST_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // Reset-sequence counter, parked at zero outside the sequence
    wire [2:0] seq_cnt_d = (in_reset_w && !seq_done_w) ? seq_cnt_q + 3'h1 : 3'h0;
    always_ff @(posedge i_clk_sys) begin
        if (any_rst_w) begin
            seq_cnt_q <= 3'h0;
        end else begin
            seq_cnt_q <= seq_cnt_d;
        end
    end

    // Program counter holds in idle; reset reloads the vector
    always_ff @(posedge i_clk_sys) begin
        if (any_rst_w) begin
            pc_q <= PC_W'(CHPC_PC_RESET);
        end else if (pc_adv_w) begin
            pc_q <= i_pc_next;
        end
    end

    // Status next values come from next state, so flags line up with it
    wire run_d      = (state_d == CHPC_ST_RUN);
    wire idle_d     = (state_d == CHPC_ST_IDLE);
    wire core_rst_d = (state_d == CHPC_ST_RESET);
    // One-cycle marker: resume from the held PC; no vector is loaded
    wire irq_srv_d  = in_idle_w & irq_wake_w & ~any_rst_w;

    // Core running flag
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            run_q <= 1'b0;
        end else begin
            run_q <= run_d;
        end
    end

    // Core idle flag, high for the whole halt
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            idle_q <= 1'b0;
        end else begin
            idle_q <= idle_d;
        end
    end

    // Reset-sequence flag; starts high so the core never runs early
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            core_rst_q <= 1'b1;
        end else begin
            core_rst_q <= core_rst_d;
        end
    end

    // Interrupt service marker after an interrupt wake
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            irq_srv_q <= 1'b0;
        end else begin
            irq_srv_q <= irq_srv_d;
        end
    end

    // Watchdog counts only when software enabled it, idle or not
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            wdt_cnt_q <= 1'b0;
        end else begin
            wdt_cnt_q <= i_wdt_en;
        end
    end

    // Peripheral enables ignore core state entirely
    assign gif.disable_req = i_periph_dis;

    chpc_periph_gate #(
        .N (N)
    ) u_gate (
        .i_clk_sys     (i_clk_sys),
        .i_rst         (i_rst),
        .i_pwr_cut_sel (i_pwr_cut_sel),
        .gif           (gif.gate)
    );

    // Clock enables retimed so the output leaves a flop
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            clk_en_q <= '1;
        end else begin
            clk_en_q <= gif.clk_en;
        end
    end

    // Power enables, same retiming; costs one cycle of latency
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            pwr_en_q <= '1;
        end else begin
            pwr_en_q <= gif.pwr_en;
        end
    end

    // Clocks never stop in idle: only the core is held
    logic osc_q;
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            osc_q <= 1'b1;
        end else begin
            osc_q <= 1'b1;
        end
    end

    assign o_core_run      = run_q;
    assign o_core_idle     = idle_q;
    assign o_core_rst      = core_rst_q;
    assign o_irq_service   = irq_srv_q;
    assign o_pc            = pc_q;
    assign o_osc_en        = osc_q;
    assign o_sysclk_en     = osc_q;
    assign o_wdt_osc_en    = osc_q;
    assign o_wdt_cnt_en    = wdt_cnt_q;
    assign o_periph_clk_en = clk_en_q;
    assign o_periph_pwr_en = pwr_en_q;
endmodule : chpc_halt_ctrl
`default_nettype wire

// ### chpc_pkg.sv
package chpc_pkg;
    // Widths and counts
    localparam int CHPC_NUM_PERIPH = 8;
    localparam int CHPC_PC_W       = 16;
    // Reset values
    localparam logic [CHPC_PC_W-1:0] CHPC_PC_RESET = 16'h0000;
    localparam logic [7:0]           CHPC_PWR_RESET = 8'h00;
    // Cycles the core spends in its reset sequence after a reset wake
    localparam int CHPC_RST_SEQ_CYC = 4;
    // Core run states
    typedef enum logic [1:0] {
        CHPC_ST_RESET,
        CHPC_ST_RUN,
        CHPC_ST_IDLE
    } chpc_state_e;
endpackage : chpc_pkg

// ### chpc_gate_if.sv
`timescale 1ns/10ps
`default_nettype none
// Per-peripheral disable request and the resulting clock/power enables
interface chpc_gate_if #(parameter int N = 8);
    logic [N-1:0] disable_req;
    logic [N-1:0] clk_en;
    logic [N-1:0] pwr_en;
    modport ctrl (output disable_req, input clk_en, input pwr_en);
    modport gate (input disable_req, output clk_en, output pwr_en);
endinterface : chpc_gate_if
`default_nettype wire

// ### chpc_periph_gate.sv
`timescale 1ns/10ps
`default_nettype none
module chpc_periph_gate
    import chpc_pkg::*;
#(
    parameter int N = CHPC_NUM_PERIPH
) (
    input  wire logic    i_clk_sys,
    input  wire logic    i_rst,
    input  wire logic [N-1:0] i_pwr_cut_sel,
    chpc_gate_if.gate    gif
);
    logic [N-1:0] clk_en_q;
    logic [N-1:0] pwr_en_q;

    // One gating cell per peripheral; core idle never touches these
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_cell
            wire cut_w = gif.disable_req[g] & i_pwr_cut_sel[g];
            wire gate_w = gif.disable_req[g] & ~i_pwr_cut_sel[g];
            always_ff @(posedge i_clk_sys) begin
                if (i_rst) begin
                    clk_en_q[g] <= 1'b1;
                    pwr_en_q[g] <= 1'b1;
                end else begin
                    clk_en_q[g] <= ~(gate_w | cut_w);
                    pwr_en_q[g] <= ~cut_w;
                end
            end
        end
    endgenerate

    assign gif.clk_en = clk_en_q;
    assign gif.pwr_en = pwr_en_q;
endmodule : chpc_periph_gate
`default_nettype wire

// ### chpc_halt_ctrl_props.sv
`timescale 1ns/10ps
`default_nettype none
module chpc_halt_ctrl_props #(
    parameter int N    = 8,
    parameter int PC_W = 16
) (
    input wire logic            i_clk_sys,
    input wire logic            i_rst,
    input wire logic            i_halt_exec,
    input wire logic            i_irq_pend,
    input wire logic            i_wdt_irq,
    input wire logic            i_wdt_rst,
    input wire logic            i_por,
    input wire logic            i_bor,
    input wire logic            i_ext_rst,
    input wire logic            i_wdt_en,
    input wire logic [N-1:0]    i_periph_dis,
    input wire logic [N-1:0]    i_pwr_cut_sel,
    input wire logic            o_core_run,
    input wire logic            o_core_idle,
    input wire logic            o_core_rst,
    input wire logic            o_irq_service,
    input wire logic [PC_W-1:0] o_pc,
    input wire logic            o_osc_en,
    input wire logic            o_sysclk_en,
    input wire logic            o_wdt_osc_en,
    input wire logic            o_wdt_cnt_en,
    input wire logic [N-1:0]    o_periph_clk_en,
    input wire logic [N-1:0]    o_periph_pwr_en
);
    // Reset-class wakes restart the core, so they are kept apart from interrupts
    wire rst_src = i_wdt_rst | i_por | i_bor | i_ext_rst;
    wire wake    = rst_src | i_irq_pend | i_wdt_irq;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    sequence s_idle_irq; o_core_idle && i_irq_pend && !rst_src; endsequence
    sequence s_resumed; o_core_run && !o_core_idle && o_irq_service ##1 !o_irq_service; endsequence
    // Past-value checks skip edges whose history lies inside reset
    chk_halt_idle: assert property (
        o_core_run && i_halt_exec && !wake |=> o_core_idle && !o_core_run)
        else $error("halt did not idle the core");
    chk_clocks_on: assert property (
        o_osc_en && o_sysclk_en && o_wdt_osc_en) else $error("clock source stopped");
    chk_pc_hold: assert property (
        o_core_idle && !rst_src |=> $stable(o_pc)) else $error("pc moved while idle");
    chk_wdt_count: assert property (
        !$past(i_rst) |-> o_wdt_cnt_en == $past(i_wdt_en)) else $error("watchdog count gate");
    chk_clk_gate: assert property (
        !$past(i_rst) && !$past(i_rst, 2) |-> o_periph_clk_en == ~$past(i_periph_dis, 2))
        else $error("peripheral clock enable wrong");
    chk_pwr_gate: assert property (
        !$past(i_rst) && !$past(i_rst, 2)
        |-> o_periph_pwr_en == ~($past(i_periph_dis, 2) & $past(i_pwr_cut_sel, 2)))
        else $error("peripheral power enable wrong");
    chk_irq_wake: assert property (
        s_idle_irq |=> s_resumed) else $error("interrupt wake not serviced");
    chk_rst_wake: assert property (
        rst_src |=> o_core_rst && !o_core_run && o_pc == '0) else $error("reset wake wrong");
    chk_rst_done: assert property (
        $fell(o_core_rst) |-> o_core_run) else $error("core not running after reset");
endmodule // chpc_halt_ctrl_props
bind chpc_halt_ctrl chpc_halt_ctrl_props #(.N(N), .PC_W(PC_W)) u_props (.*);
`default_nettype wire

// ### tb_cpu_halt_power_control.sv
`timescale 1ns/10ps
`default_nettype none
module tb_cpu_halt_power_control;
    typedef struct {int due; logic [39:0] v; logic [39:0] m;} chpc_exp_s;
    logic        i_clk_sys = 0, i_rst = 1, halt = 0, step = 0, wdt = 0, run, idle;
    logic        core_rst, irq_srv, wdt_cnt, osc_en, sys_en, wdt_osc;
    logic [5:0]  wk = '0;
    logic [15:0] nxt = '0, pc_p, pc;
    logic [7:0]  dis = '0, sel = '0, clk_en, pwr_en;
    logic [19:0] exw;
    logic [39:0] got;
    chpc_exp_s   q[$], e;
    int          n = 0, tmo = 0, err_total = 0, compares = 0;
    assign got = {osc_en, sys_en, wdt_osc, wdt_cnt, core_rst, irq_srv, idle, run, pc, clk_en,
                  pwr_en};
    chpc_halt_ctrl i_dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_halt_exec(halt),
        .i_irq_pend(wk[0]), .i_wdt_irq(wk[1]), .i_wdt_rst(wk[2]), .i_por(wk[3]),
        .i_bor(wk[4]), .i_ext_rst(wk[5]), .i_wdt_en(wdt), .i_pc_step(step), .i_pc_next(nxt),
        .i_periph_dis(dis), .i_pwr_cut_sel(sel), .o_core_run(run), .o_core_idle(idle),
        .o_core_rst(core_rst), .o_irq_service(irq_srv), .o_pc(pc), .o_osc_en(osc_en),
        .o_sysclk_en(sys_en), .o_wdt_osc_en(wdt_osc), .o_wdt_cnt_en(wdt_cnt),
        .o_periph_clk_en(clk_en), .o_periph_pwr_en(pwr_en));
    initial begin
        forever #12.5 i_clk_sys = ~i_clk_sys;
    end
    task automatic print_verdict;
        $display("compares=%0d errors=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Core state is due one edge later, peripheral enables two edges later
    // Core note: clocks on, watchdog gate, reset, service, idle, run, pc
    task automatic tick(input logic h, s, input logic [15:0] x, input logic [5:0] w,
                        input logic [19:0] ex, input logic c);
        logic [7:0] d;
        logic [7:0] p;
        logic       we;
        d  = 8'($urandom);
        p  = 8'($urandom);
        we = 1'($urandom);
        @(posedge i_clk_sys);
        n++;
        halt <= h;
        step <= s;
        nxt  <= x;
        wk   <= w;
        dis  <= d;
        sel  <= p;
        wdt  <= we;
        q.push_back(chpc_exp_s'{n + 1, {3'b111, we, ex, 16'h0000}, {4'hf, {20{c}}, 16'h0000}});
        q.push_back(chpc_exp_s'{n + 2, {24'h00_0000, ~d, ~(d & p)}, {24'h00_0000, 16'hffff}});
    endtask
    // Bounded wait for the core to come out of its reset sequence
    task automatic wait_run;
        repeat (20) begin
            tick(0, 0, '0, '0, '0, 0);
            #1;
            if (run === 1'b1) return;
        end
        err_total++;
    endtask
    // Scoreboard: oldest note against the settled outputs
    always @(negedge i_clk_sys) begin
        while (q.size() > 0 && q[0].due == n) begin
            e = q.pop_front();
            compares++;
            if ((got & e.m) !== (e.v & e.m)) begin
                err_total++;
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got & e.m, e.v & e.m);
            end
        end
    end
    // Hang guard, generous against roughly 55 cycles of traffic
    always @(posedge i_clk_sys) begin
        tmo <= tmo + 1;
        if (tmo == 2000) begin
            err_total++;
            print_verdict();
        end
    end
    // Each wake source in turn: irq, watchdog irq, then four reset kinds
    initial begin
        void'($urandom(32'hb99f));
        repeat (5) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        for (int k = 0; k < 6; k++) begin
            pc_p = 16'($urandom);
            exw = (k < 2) ? {4'b0001, pc_p} : 20'h8_0000;
            wait_run();
            tick(0, 1, pc_p, '0, {4'b0001, pc_p}, 1);
            tick(1, 1, ~pc_p, '0, {4'b0010, pc_p}, 1);
            tick(0, 1, pc_p + 16'h0001, '0, {4'b0010, pc_p}, 1);
            tick(0, 0, pc_p, 6'(1 << k), (k < 2) ? {4'b0101, pc_p} : 20'h8_0000, 1);
            tick(0, 0, pc_p, '0, exw, 1);
            $display("test %0d done", k);
        end
        repeat (2) tick(0, 0, '0, '0, '0, 0);
        // Let the last scoreboard pass finish before the verdict
        @(negedge i_clk_sys);
        #1;
        print_verdict();
    end
endmodule // tb_cpu_halt_power_control
`default_nettype wire
